// [msn_pkg.sv]
package msn_pkg;

  localparam logic [7:0] ADDR_BYTE0   = 8'he9;
  localparam logic [7:0] ADDR_BYTE5   = 8'hee;
  localparam logic [7:0] ADDR_CTRL    = 8'hef;
  localparam int         NUM_BYTES    = 6;

  localparam int         CTRL_ERR_BIT = 7;
  localparam int         CTRL_OVF_BIT = 6;
  localparam int         CTRL_DIR_BIT = 5;
  localparam int         SC_WIDTH     = 5;
  localparam logic [7:0] BYTE_RESET   = 8'h00;
  localparam logic [4:0] SC_RESET     = 5'h00;

  localparam int         MCYCLE_CLKS  = 6;
  localparam logic [2:0] FIRST_STEP   = 3'h4;
  localparam logic [2:0] NEXT_STEP    = 3'h6;
  localparam logic [4:0] NORM_MAX     = 5'h1f;
  localparam int         NORM_MAX_MC  = 6;
  localparam int         DIV_STEPS    = 32;

  typedef enum logic [2:0] {
    SEQ_IDLE    = 3'b000,
    SEQ_LOAD0   = 3'b001,
    SEQ_LOAD1   = 3'b010,
    SEQ_LONG    = 3'b011,
    SEQ_SHORT   = 3'b100,
    SEQ_MULSEL  = 3'b101,
    SEQ_RES_LO  = 3'b110,
    SEQ_RES_DIV = 3'b111
  } msn_seq_t;

endpackage

// [msn_shifter.sv]
`timescale 1ns/1ps
`default_nettype none
module msn_shifter #(
  parameter int WIDTH = 32
) (
  // Operand
  input  wire logic [WIDTH-1:0] i_value,
  input  wire logic             i_right,
  input  wire logic [2:0]       i_amount,
  // Result
  output logic      [WIDTH-1:0] o_value
);

  // Logical shifts, so only zeros fill the vacated end
  assign o_value = i_right ? (i_value >> i_amount) : (i_value << i_amount);

endmodule // msn_shifter
`default_nettype wire

// [msn_divider.sv]
`timescale 1ns/1ps
`default_nettype none
module msn_divider #(
  parameter int STEPS = msn_pkg::DIV_STEPS
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Control
  input  wire logic        i_start,
  input  wire logic        i_mul,
  input  wire logic        i_abort,
  input  wire logic [31:0] i_dividend,
  input  wire logic [15:0] i_divisor,
  // Result
  output logic             o_busy,
  output logic             o_done,
  output logic             o_ovf,
  output logic [31:0]      o_quot,
  output logic [15:0]      o_rem
);

  logic [15:0] div_reg;
  logic [5:0]  cnt_reg;
  logic [17:0] trial;
  logic [31:0] prod;

  assign trial = {1'b0, o_rem, o_quot[31]} - {2'b00, div_reg};
  // Operands widened first so the full 32-bit product is kept
  assign prod  = {16'h0, i_dividend[15:0]} * {16'h0, i_divisor};

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_busy  <= 1'b0;
      o_done  <= 1'b0;
      o_ovf   <= 1'b0;
      o_quot  <= 32'h0;
      o_rem   <= 16'h0;
      div_reg <= 16'h0;
      cnt_reg <= 6'h0;
    end else begin
      o_done <= 1'b0;
      if (i_abort) begin
        o_busy <= 1'b0;
      end else if (i_start && i_mul) begin
        o_quot <= prod;
        o_ovf  <= prod > 32'h0000ffff;
        o_done <= 1'b1;
      end else if (i_start && (i_divisor == 16'h0)) begin
        // Zero divisor: saturated quotient, low 16 dividend bits kept as remainder
        o_quot <= 32'hffffffff;
        o_rem  <= i_dividend[15:0];
        o_ovf  <= 1'b1;
        o_done <= 1'b1;
      end else if (i_start) begin
        o_quot  <= i_dividend;
        o_rem   <= 16'h0;
        o_ovf   <= 1'b0;
        div_reg <= i_divisor;
        cnt_reg <= 6'(STEPS);
        o_busy  <= 1'b1;
      end else if (o_busy) begin
        if (!trial[17]) begin
          o_rem  <= trial[15:0];
          o_quot <= {o_quot[30:0], 1'b1};
        end else begin
          o_rem  <= {o_rem[14:0], o_quot[31]};
          o_quot <= {o_quot[30:0], 1'b0};
        end
        cnt_reg <= cnt_reg - 6'h1;
        if (cnt_reg == 6'h1) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end
      end
    end
  end

endmodule // msn_divider
`default_nettype wire

// [msn_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module msn_unit (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  // Special function register access
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_wr,
  input  wire logic       i_sfr_rd,
  input  wire logic [7:0] i_sfr_wdata,
  output logic      [7:0] o_sfr_rdata,
  output logic            o_sfr_sel
);

  logic [7:0]       md_reg [msn_pkg::NUM_BYTES];
  logic [5:0]       wr_b;
  logic [5:0]       rd_b;
  logic             wr_ctrl;
  logic             rd_ctrl;
  logic [2:0]       mc_cnt_reg;
  logic             mc_tick;
  logic             sh_busy_reg;
  logic             sh_first_reg;
  logic             sh_right_reg;
  logic [4:0]       sh_rem_reg;
  logic [4:0]       sc_reg;
  logic             dir_reg;
  logic             ovf_reg;
  logic             err_reg;
  logic             err_set;
  logic [2:0]       step;
  logic [2:0]       amt;
  logic [31:0]      cur_val;
  logic [31:0]      sh_val;
  logic [4:0]       norm_cnt;
  logic             start_norm;
  logic             start_shift;
  logic             armed;
  logic             eng_start;
  logic             eng_mul;
  logic             eng_busy;
  logic             eng_done;
  logic             eng_ovf;
  logic             eng_div_reg;
  logic [31:0]      eng_quot;
  logic [15:0]      eng_rem;
  msn_pkg::msn_seq_t seq_reg;

  function automatic logic [4:0] lead_zero_cap(input logic [31:0] v);
    logic [4:0] n;
    n = msn_pkg::NORM_MAX;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        n = 5'(31 - i);
      end
    end
    return n;
  endfunction

  always_comb begin
    for (int i = 0; i < msn_pkg::NUM_BYTES; i++) begin
      wr_b[i] = i_sfr_wr && (i_sfr_addr == msn_pkg::ADDR_BYTE0 + 8'(i));
      rd_b[i] = i_sfr_rd && (i_sfr_addr == msn_pkg::ADDR_BYTE0 + 8'(i));
    end
  end

  assign wr_ctrl     = i_sfr_wr && (i_sfr_addr == msn_pkg::ADDR_CTRL);
  assign rd_ctrl     = i_sfr_rd && (i_sfr_addr == msn_pkg::ADDR_CTRL);
  assign o_sfr_sel   = (i_sfr_addr >= msn_pkg::ADDR_BYTE0) && (i_sfr_addr <= msn_pkg::ADDR_CTRL);
  assign cur_val     = {md_reg[3], md_reg[2], md_reg[1], md_reg[0]};
  assign norm_cnt    = lead_zero_cap(cur_val);
  assign start_norm  = wr_ctrl && (i_sfr_wdata[msn_pkg::SC_WIDTH-1:0] == 5'h0);
  assign start_shift = wr_ctrl && (i_sfr_wdata[msn_pkg::SC_WIDTH-1:0] != 5'h0);
  assign armed       = (seq_reg != msn_pkg::SEQ_IDLE);

  // Machine cycle enable
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mc_cnt_reg <= 3'h0;
    end else if (mc_cnt_reg == 3'(msn_pkg::MCYCLE_CLKS - 1)) begin
      mc_cnt_reg <= 3'h0;
    end else begin
      mc_cnt_reg <= mc_cnt_reg + 3'h1;
    end
  end
  assign mc_tick = (mc_cnt_reg == 3'(msn_pkg::MCYCLE_CLKS - 1));

  assign step = sh_first_reg ? msn_pkg::FIRST_STEP : msn_pkg::NEXT_STEP;
  assign amt  = ({2'b00, step} > sh_rem_reg) ? sh_rem_reg[2:0] : step;

  msn_shifter #(
    .WIDTH(32)
  ) u_shifter (
    .i_value (cur_val),
    .i_right (sh_right_reg),
    .i_amount(amt),
    .o_value (sh_val)
  );

  // Shift engine; normalize becomes a left shift by the leading zero count
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sh_busy_reg  <= 1'b0;
      sh_first_reg <= 1'b0;
      sh_right_reg <= 1'b0;
      sh_rem_reg   <= 5'h0;
    end else if (wr_b[0]) begin
      sh_busy_reg <= 1'b0;
    end else if (start_norm) begin
      sh_right_reg <= 1'b0;
      sh_rem_reg   <= norm_cnt;
      sh_first_reg <= 1'b1;
      sh_busy_reg  <= (norm_cnt != 5'h0);
    end else if (start_shift) begin
      sh_right_reg <= i_sfr_wdata[msn_pkg::CTRL_DIR_BIT];
      sh_rem_reg   <= i_sfr_wdata[msn_pkg::SC_WIDTH-1:0];
      sh_first_reg <= 1'b1;
      sh_busy_reg  <= 1'b1;
    end else if (sh_busy_reg && mc_tick) begin
      sh_rem_reg   <= sh_rem_reg - {2'b00, amt};
      sh_first_reg <= 1'b0;
      sh_busy_reg  <= (sh_rem_reg != {2'b00, amt});
    end
  end

  // Control fields
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sc_reg  <= msn_pkg::SC_RESET;
      dir_reg <= 1'b0;
    end else if (start_norm) begin
      sc_reg  <= norm_cnt;
      dir_reg <= i_sfr_wdata[msn_pkg::CTRL_DIR_BIT];
    end else if (start_shift) begin
      sc_reg  <= i_sfr_wdata[msn_pkg::SC_WIDTH-1:0];
      dir_reg <= i_sfr_wdata[msn_pkg::CTRL_DIR_BIT];
    end
  end

  // Overflow is hardware owned; the written bit 6 is dropped
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ovf_reg <= 1'b0;
    end else if (start_norm) begin
      ovf_reg <= md_reg[3][7];
    end else if (start_shift) begin
      ovf_reg <= 1'b0;
    end else if (eng_done) begin
      ovf_reg <= eng_ovf;
    end
  end

  // Write order selects the arithmetic operation
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      seq_reg <= msn_pkg::SEQ_IDLE;
    end else if (wr_b[0]) begin
      seq_reg <= msn_pkg::SEQ_LOAD0;
    end else if (wr_ctrl) begin
      seq_reg <= msn_pkg::SEQ_RES_LO;
    end else begin
      case (seq_reg)
        msn_pkg::SEQ_LOAD0: begin
          if (wr_b[1]) begin
            seq_reg <= msn_pkg::SEQ_LOAD1;
          end else if (wr_b[4]) begin
            seq_reg <= msn_pkg::SEQ_MULSEL;
          end
        end
        msn_pkg::SEQ_LOAD1: begin
          if (wr_b[2]) begin
            seq_reg <= msn_pkg::SEQ_LONG;
          end else if (wr_b[4]) begin
            seq_reg <= msn_pkg::SEQ_SHORT;
          end
        end
        msn_pkg::SEQ_LONG, msn_pkg::SEQ_SHORT: begin
          if (wr_b[5]) begin
            seq_reg <= msn_pkg::SEQ_RES_DIV;
          end
        end
        msn_pkg::SEQ_MULSEL: begin
          if (wr_b[5]) begin
            seq_reg <= msn_pkg::SEQ_RES_LO;
          end
        end
        msn_pkg::SEQ_RES_LO: begin
          if (rd_b[3]) begin
            seq_reg <= msn_pkg::SEQ_IDLE;
          end
        end
        msn_pkg::SEQ_RES_DIV: begin
          if (rd_b[5]) begin
            seq_reg <= msn_pkg::SEQ_IDLE;
          end
        end
        default: begin
          seq_reg <= msn_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  assign eng_start = wr_b[5] && ((seq_reg == msn_pkg::SEQ_LONG) || (seq_reg == msn_pkg::SEQ_SHORT) ||
                                 (seq_reg == msn_pkg::SEQ_MULSEL));
  assign eng_mul   = (seq_reg == msn_pkg::SEQ_MULSEL);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      eng_div_reg <= 1'b0;
    end else if (eng_start) begin
      eng_div_reg <= !eng_mul;
    end
  end

  msn_divider #(
    .STEPS(msn_pkg::DIV_STEPS)
  ) u_divider (
    .i_clk     (i_clk),
    .i_rstn    (i_rstn),
    .i_start   (eng_start),
    .i_mul     (eng_mul),
    .i_abort   (wr_b[0] || wr_ctrl),
    .i_dividend(seq_reg == msn_pkg::SEQ_LONG ? cur_val : {16'h0, md_reg[1], md_reg[0]}),
    .i_divisor ({i_sfr_wdata, md_reg[4]}),
    .o_busy    (eng_busy),
    .o_done    (eng_done),
    .o_ovf     (eng_ovf),
    .o_quot    (eng_quot),
    .o_rem     (eng_rem)
  );

  // Operand/result bytes; reads never disturb them, so results wait forever
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < msn_pkg::NUM_BYTES; i++) begin
        md_reg[i] <= msn_pkg::BYTE_RESET;
      end
    end else if (wr_b[0]) begin
      md_reg[0] <= i_sfr_wdata;
    end else if (eng_done && !wr_ctrl) begin
      {md_reg[3], md_reg[2], md_reg[1], md_reg[0]} <= eng_quot;
      if (eng_div_reg) begin
        {md_reg[5], md_reg[4]} <= eng_rem;
      end
    end else if (sh_busy_reg && mc_tick && !wr_ctrl) begin
      {md_reg[3], md_reg[2], md_reg[1], md_reg[0]} <= sh_val;
    end else if (!sh_busy_reg && !eng_busy) begin
      // Writes to bytes 1 to 5 during a running shift or divide are dropped to protect it
      for (int i = 1; i < msn_pkg::NUM_BYTES; i++) begin
        if (wr_b[i]) begin
          md_reg[i] <= i_sfr_wdata;
        end
      end
    end
  end

  // Error flag: set wins over the read clear
  assign err_set = (wr_b[0] && armed) || (sh_busy_reg && ((|rd_b[3:0]) || wr_b[0]));
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      err_reg <= 1'b0;
    end else if (err_set) begin
      err_reg <= 1'b1;
    end else if (rd_ctrl) begin
      err_reg <= 1'b0;
    end
  end

  // Read data registered one clock after the strobe
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sfr_rdata <= 8'h00;
    end else if (rd_ctrl) begin
      o_sfr_rdata <= {err_reg, ovf_reg, dir_reg, sc_reg};
    end else if (i_sfr_rd) begin
      o_sfr_rdata <= 8'h00;
      for (int i = 0; i < msn_pkg::NUM_BYTES; i++) begin
        if (rd_b[i]) begin
          o_sfr_rdata <= md_reg[i];
        end
      end
    end
  end

  a_norm_bound: assert property (@(posedge i_clk) disable iff (!i_rstn)
    start_norm |-> ##[1:42] !sh_busy_reg) else $error("normalize too slow");
  a_norm_msb: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (start_norm && cur_val != 32'h0) ##1 (!wr_b[0] && !wr_ctrl)[*7] |-> md_reg[3][7] || sh_busy_reg)
    else $error("normalize left msb clear");
  a_norm_ovf: assert property (@(posedge i_clk) disable iff (!i_rstn)
    start_norm |=> ovf_reg == $past(md_reg[3][7])) else $error("normalize overflow wrong");
  a_norm_count: assert property (@(posedge i_clk) disable iff (!i_rstn)
    start_norm |=> sc_reg == $past(norm_cnt)) else $error("normalize count wrong");
  a_shift_ovf_clr: assert property (@(posedge i_clk) disable iff (!i_rstn)
    start_shift |=> !ovf_reg) else $error("shift kept overflow");
  a_first_step: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (sh_busy_reg && sh_first_reg && mc_tick && sh_rem_reg > 5'h4 && !wr_b[0] && !wr_ctrl)
    |=> sh_rem_reg == $past(sh_rem_reg) - 5'h4) else $error("first step not four");
  a_later_step: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (sh_busy_reg && !sh_first_reg && mc_tick && sh_rem_reg > 5'h6 && !wr_b[0] && !wr_ctrl)
    |=> sh_rem_reg == $past(sh_rem_reg) - 5'h6) else $error("later step not six");
  a_err_rewrite: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (wr_b[0] && armed) |=> err_reg) else $error("rewrite not flagged");
  a_err_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (rd_ctrl && !err_set) |=> !err_reg) else $error("error flag not cleared");
  a_div_disarm: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (seq_reg == msn_pkg::SEQ_RES_DIV && rd_b[5] && !i_sfr_wr) |=> !armed) else $error("divide not disarmed");

endmodule // msn_unit
`default_nettype wire

// [msn_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module msn_cpu_model (
  // Clock
  input  wire logic       i_clk,
  // Special function register access
  output logic      [7:0] o_addr,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_wdata
);
  initial begin
    o_addr  = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_wdata = 8'h00;
  end

  // One strobe per access, raised and dropped on falling edges
  // Data shows its inverse once released so stale values never match
  task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(negedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= w;
    o_rd    <= !w;
    @(negedge i_clk);
    o_wr    <= 1'b0;
    o_rd    <= 1'b0;
    o_wdata <= ~d;
  endtask
endmodule // msn_cpu_model
`default_nettype wire

// [muldiv_shift_normalize_unit_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module muldiv_shift_normalize_unit_tb_top;
  localparam logic [7:0] B0 = msn_pkg::ADDR_BYTE0;
  localparam logic [7:0] B5 = msn_pkg::ADDR_BYTE5;
  localparam logic [7:0] CT = msn_pkg::ADDR_CTRL;
  logic        i_clk;
  logic        i_rstn;
  logic [7:0]  addr;
  logic        wr;
  logic        rd;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        sel;
  logic        rd_seen;
  logic [15:0] exp_q[$];
  logic [15:0] qi;
  int          err_count;
  int          checks;
  int          cyc;
  logic [31:0] v;
  logic [4:0]  c;
  logic        dr;
  logic [4:0]  sc_tbl[5] = '{5'h01, 5'h04, 5'h05, 5'h0a, 5'h1f};

  msn_cpu_model msn_cpu_model_inst (.i_clk(i_clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
  msn_unit msn_unit_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd),
                          .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .o_sfr_sel(sel));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    checks++;
    if (seen !== ex) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task automatic report_and_stop();
    chk("pending", 32'(exp_q.size()), 32'h0);
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
    msn_cpu_model_inst.access(a, d, 1'b1);
  endtask

  // Mask zero marks a read whose data is not yet defined
  task automatic rd_b(input logic [7:0] a, input logic [7:0] ex, input logic [7:0] mk);
    exp_q.push_back({mk, ex & mk});
    msn_cpu_model_inst.access(a, 8'h00, 1'b0);
  endtask

  task automatic ld32(input logic [31:0] x);
    for (int i = 0; i < 4; i++) wr_b(B0 + 8'(i), x[8*i+:8]);
  endtask

  task automatic rd32(input logic [31:0] x);
    for (int i = 0; i < 4; i++) rd_b(B0 + 8'(i), x[8*i+:8], 8'hff);
  endtask

  function automatic logic [4:0] lz(input logic [31:0] x);
    for (int i = 31; i >= 1; i--) if (x[i]) return 5'(31 - i);
    return 5'h1f;
  endfunction

  task automatic mul(input logic [15:0] a, input logic [15:0] b, input logic er);
    logic [31:0] p;
    p = a * b;
    wr_b(B0, a[7:0]);
    wr_b(B0 + 8'h4, b[7:0]);
    wr_b(B0 + 8'h1, a[15:8]);
    wr_b(B5, b[15:8]);
    tick(3);
    rd32(p);
    rd_b(CT, {er, p > 32'hffff, 6'h0}, 8'hc0);
  endtask

  task automatic div(input logic [31:0] dv, input logic [15:0] ds, input logic wide);
    logic [31:0] q;
    logic [15:0] r;
    q = (ds == 16'h0) ? 32'hffffffff : dv / ds;
    r = (ds == 16'h0) ? dv[15:0] : 16'(dv % ds);
    wr_b(B0, dv[7:0]);
    wr_b(B0 + 8'h1, dv[15:8]);
    if (wide) begin
      wr_b(B0 + 8'h2, dv[23:16]);
      wr_b(B0 + 8'h3, dv[31:24]);
    end
    wr_b(B0 + 8'h4, ds[7:0]);
    wr_b(B5, ds[15:8]);
    tick(40);
    rd32(q);
    rd_b(B0 + 8'h4, r[7:0], 8'hff);
    rd_b(B5, r[15:8], 8'hff);
    rd_b(CT, {1'b0, ds == 16'h0, 6'h0}, 8'hc0);
  endtask

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) rd_seen <= 1'b0;
    else rd_seen <= rd;
  end

  always @(negedge i_clk) begin
    if (rd_seen === 1'b1 && exp_q.size() > 0) begin
      qi = exp_q.pop_front();
      chk("rdata", 32'(rdata & qi[15:8]), 32'(qi[7:0]));
    end
  end

  always @(posedge i_clk) begin
    cyc++;
    if (wr || rd) chk("sel", 32'(sel), 32'(addr >= B0 && addr <= CT));
    if (cyc > 6000) begin
      err_count++;
      report_and_stop();
    end
  end

  initial begin
    i_rstn    = 1'b0;
    err_count = 0;
    checks    = 0;
    cyc       = 0;
    void'($urandom(32'h7620));
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    i_rstn = 1'b1;
    for (int i = 0; i < 7; i++) rd_b(B0 + 8'(i), 8'h00, 8'hff);
    rd_b(8'h80, 8'h00, 8'hff);
    // Normalize, overflow case last so the first shift must clear it
    for (int k = 0; k < 4; k++) begin
      case (k)
        0: v = $urandom >> ($urandom % 30 + 1);
        1: v = 32'h0;
        2: v = 32'h1;
        default: v = 32'h80000001;
      endcase
      c = v[31] ? 5'h00 : lz(v);
      ld32(v);
      wr_b(CT, 8'hc0);
      tick(40);
      rd32(v << c);
      rd_b(CT, {1'b0, v[31], 1'b0, c}, 8'hff);
    end
    for (int k = 0; k < 6; k++) begin
      v  = $urandom;
      dr = 1'($urandom);
      c  = (k < 5) ? sc_tbl[k] : 5'($urandom % 31 + 1);
      ld32(v);
      wr_b(CT, {2'b11, dr, c});
      tick(40);
      rd32(dr ? v >> c : v << c);
      rd_b(CT, {2'b00, dr, 5'h00}, 8'he0);
    end
    // Early read while a long shift runs
    v = $urandom;
    ld32(v);
    wr_b(CT, 8'h1f);
    rd_b(B0, 8'h00, 8'h00);
    tick(40);
    rd32(v << 31);
    rd_b(CT, 8'h80, 8'h80);
    rd_b(CT, 8'h00, 8'h80);
    wr_b(B0, 8'h5a);
    mul(16'($urandom), 16'($urandom), 1'b1);
    mul(16'h00ff, 16'h0101, 1'b0);
    mul(16'h0100, 16'h0100, 1'b0);
    mul(16'($urandom), 16'($urandom), 1'b0);
    div($urandom, 16'($urandom) | 16'h1, 1'b1);
    div($urandom, 16'h0, 1'b1);
    div({16'h0, 16'($urandom)}, 16'($urandom) | 16'h1, 1'b0);
    tick(2);
    report_and_stop();
  end
endmodule // muldiv_shift_normalize_unit_tb_top
`default_nettype wire
